// ==== core/tpdo_pkg.sv ====
// Shared types and constants for the transmit process-data scheduler
package tpdo_pkg;

  // ----------------------------------------------------------------
  // Register map: word address = {object index, sub-index}
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SYNC_ID = 16'h1005;
  localparam logic [15:0] IDX_COMM_BASE = 16'h1800;
  localparam logic [15:0] IDX_MAP_BASE = 16'h1A00;
  localparam logic [15:0] IDX_STATUS = 16'h2F00;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FRAME_ID = 8'h01;
  localparam logic [7:0] SUB_TX_TYPE = 8'h02;
  localparam logic [7:0] SUB_INHIBIT = 8'h03;
  localparam logic [7:0] SUB_EVENT_TIMER = 8'h05;
  localparam int NUM_TPDO = 2;
  localparam int NUM_MAP = 4;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] SYNC_ID_RESET = 32'h0000_0080;
  localparam logic [7:0] COMM_COUNT_VALUE = 8'h05;
  localparam logic [7:0] TX_TYPE_RESET = 8'hFE;
  localparam logic [10:0] FRAME_ID_BASE0 = 11'h180;
  localparam logic [10:0] FRAME_ID_BASE1 = 11'h280;
  localparam int ID_DISABLE_BIT = 31;
  localparam logic [31:0] ID_KEEP_MASK = 32'h8000_07FF;
  localparam logic [9:0] MAX_MAP_BITS = 10'h040;
  localparam logic [7:0] TT_SYNC_ACYCLIC = 8'h00;
  localparam logic [7:0] TT_SYNC_MAX = 8'hF0;
  localparam logic [7:0] TT_SYNC_RTR = 8'hFC;
  localparam logic [7:0] TT_RTR_ONLY = 8'hFD;
  localparam logic [7:0] TT_TIMER = 8'hFE;
  localparam logic [7:0] TT_CHANGE = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_KHZ = 250000;
  localparam int unsigned INHIBIT_UNIT_US = 100;
  localparam int unsigned EVENT_UNIT_US = 1000;
  localparam int unsigned INHIBIT_UNIT_CYCLES = INHIBIT_UNIT_US * CLOCK_KHZ / 1000;
  localparam int unsigned EVENT_PER_INHIBIT = EVENT_UNIT_US / INHIBIT_UNIT_US;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic rtr;
    logic [10:0] id;
  } rx_frame_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } tx_frame_t;

  typedef enum logic [1:0] {SCAN_FETCH, SCAN_DECIDE} scan_t;

  typedef struct packed {
    logic [31:0] frame_id;
    logic [7:0] tx_type;
    logic [15:0] inhibit;
    logic [15:0] event_timer;
    logic [2:0] map_cnt;
    logic [3:0][31:0] map;
    logic [7:0] sync_cnt;
    logic [16:0] inh_cnt;
    logic [15:0] evt_cnt;
    logic [63:0] latched;
    logic [3:0] latched_dlc;
    logic [63:0] last;
    logic sent_once;
    logic sync_hit;
    logic rtr_hit;
    logic tmr_hit;
    logic due;
    logic [63:0] due_data;
    logic [3:0] due_dlc;
  } pdo_t;

endpackage

// ==== core/tpdo_scheduler.sv ====
// Transmit process-data scheduler with Avalon-MM register slave
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps

module tpdo_scheduler #(
  parameter int unsigned INHIBIT_UNIT_CYCLES = tpdo_pkg::INHIBIT_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [23:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  input wire tpdo_pkg::rx_frame_t rx_frame,
  output tpdo_pkg::tx_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [15:0] obj_index,
  output logic [7:0] obj_sub,
  input wire logic [31:0] obj_value
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic init;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] sync_id;
    tpdo_pkg::pdo_t [1:0] pdo;
    tpdo_pkg::scan_t scan;
    logic pidx;
    logic [2:0] entry;
    logic [3:0] offset;
    logic [63:0] build;
    logic [17:0] pre_cnt;
    logic [3:0] ms_cnt;
    logic tx_busy;
    tpdo_pkg::tx_frame_t tx;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Total mapped length in bits of the first cnt entries
  function automatic logic [9:0] map_bits(logic [3:0][31:0] m, logic [2:0] cnt);
    logic [9:0] sum;
    sum = '0;
    for (int i = 0; i < tpdo_pkg::NUM_MAP; i++) begin
      if (3'(i) < cnt) begin
        sum = sum + {2'h0, m[i][7:0]};
      end
    end
    return sum;
  endfunction

  // Drop the low bytes of a value into the payload, little-endian
  function automatic logic [63:0] put_bytes(logic [63:0] buf_in, logic [3:0] off,
                                            logic [31:0] val, logic [3:0] nbytes);
    logic [63:0] r;
    r = buf_in;
    for (int i = 0; i < 4; i++) begin
      if ((i < int'(nbytes)) && (int'(off) + i < 8)) begin
        r[(int'(off) + i) * 8 +: 8] = val[i * 8 +: 8];
      end
    end
    return r;
  endfunction

  // A PDO may only act when operational, enabled and mapped
  function automatic logic pdo_active(tpdo_pkg::pdo_t p, logic op);
    return op && !p.frame_id[tpdo_pkg::ID_DISABLE_BIT] && (p.map_cnt != 3'h0);
  endfunction

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Waitrequest is combinational so the answer lands on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !st_q.ack;
  assign avs_readdata = st_q.rdata;
  assign tx_valid = st_q.tx_busy;
  assign tx_frame = st_q.tx;
  assign obj_index = st_q.pdo[st_q.pidx].map[st_q.entry[1:0]][31:16];
  assign obj_sub = st_q.pdo[st_q.pidx].map[st_q.entry[1:0]][15:8];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] idx;
    logic [7:0] sub;
    logic p;
    logic tick100;
    logic tick_ms;
    logic sync_evt;
    logic send;
    logic [63:0] sdata;
    logic [3:0] sdlc;
    logic [3:0] nbytes;
    logic [7:0] next_cnt;
    logic changed;
    tpdo_pkg::pdo_t cur;
    idx = avs_address[23:8];
    sub = avs_address[7:0];
    p = st_q.pidx;
    tick100 = 1'b0;
    tick_ms = 1'b0;
    sync_evt = 1'b0;
    send = 1'b0;
    sdata = '0;
    sdlc = '0;
    nbytes = '0;
    next_cnt = '0;
    changed = 1'b0;
    st_d = st_q;
    cur = st_q.pdo[p];

    // Identifier defaults once node_id has settled
    if (!st_q.init) begin
      st_d.init = 1'b1;
      st_d.pdo[0].frame_id = {21'h0, tpdo_pkg::FRAME_ID_BASE0 + {4'h0, node_id}};
      st_d.pdo[1].frame_id = {21'h0, tpdo_pkg::FRAME_ID_BASE1 + {4'h0, node_id}};
    end

    // Bus slave: act on first cycle, ack on the next
    st_d.ack = 1'b0;
    if ((avs_read || avs_write) && !st_q.ack && st_q.init) begin
      st_d.ack = 1'b1;
      st_d.rdata = '0;
      if (idx == tpdo_pkg::IDX_SYNC_ID && sub == tpdo_pkg::SUB_COUNT) begin
        st_d.rdata = st_q.sync_id;
        if (avs_write) begin
          st_d.sync_id = avs_writedata;
        end
      end
      for (int i = 0; i < tpdo_pkg::NUM_TPDO; i++) begin
        if (idx == tpdo_pkg::IDX_COMM_BASE + 16'(i)) begin
          case (sub)
            tpdo_pkg::SUB_COUNT: st_d.rdata = {24'h0, tpdo_pkg::COMM_COUNT_VALUE};
            tpdo_pkg::SUB_FRAME_ID: begin
              st_d.rdata = st_q.pdo[i].frame_id;
              if (avs_write) begin
                st_d.pdo[i].frame_id = avs_writedata & tpdo_pkg::ID_KEEP_MASK;
              end
            end
            tpdo_pkg::SUB_TX_TYPE: begin
              st_d.rdata = {24'h0, st_q.pdo[i].tx_type};
              if (avs_write) begin
                st_d.pdo[i].tx_type = avs_writedata[7:0];
                st_d.pdo[i].sync_cnt = '0;
                st_d.pdo[i].sent_once = 1'b0;
              end
            end
            tpdo_pkg::SUB_INHIBIT: begin
              st_d.rdata = {16'h0, st_q.pdo[i].inhibit};
              if (avs_write) begin
                st_d.pdo[i].inhibit = avs_writedata[15:0];
              end
            end
            tpdo_pkg::SUB_EVENT_TIMER: begin
              st_d.rdata = {16'h0, st_q.pdo[i].event_timer};
              if (avs_write) begin
                st_d.pdo[i].event_timer = avs_writedata[15:0];
                st_d.pdo[i].evt_cnt = '0;
              end
            end
            default: st_d.rdata = '0;
          endcase
        end
        if (idx == tpdo_pkg::IDX_MAP_BASE + 16'(i)) begin
          if (sub == tpdo_pkg::SUB_COUNT) begin
            st_d.rdata = {29'h0, st_q.pdo[i].map_cnt};
            // Zero always accepted; a new count only if it fits the frame
            if (avs_write && avs_writedata == 32'h0) begin
              st_d.pdo[i].map_cnt = 3'h0;
            end else if (avs_write && avs_writedata <= 32'(tpdo_pkg::NUM_MAP) &&
                         map_bits(st_q.pdo[i].map, avs_writedata[2:0]) <=
                         tpdo_pkg::MAX_MAP_BITS) begin
              st_d.pdo[i].map_cnt = avs_writedata[2:0];
              st_d.pdo[i].sent_once = 1'b0;
            end
          end else if (sub >= 8'h01 && sub <= 8'(tpdo_pkg::NUM_MAP)) begin
            st_d.rdata = st_q.pdo[i].map[sub[1:0] - 2'h1];
            // Entries are frozen while the PDO is mapped
            if (avs_write && st_q.pdo[i].map_cnt == 3'h0) begin
              st_d.pdo[i].map[sub[1:0] - 2'h1] = avs_writedata;
            end
          end
        end
        if (idx == tpdo_pkg::IDX_STATUS && sub == 8'(i)) begin
          st_d.rdata = {13'h0, st_q.pdo[i].due, (st_q.pdo[i].inh_cnt != 17'h0),
                        pdo_active(st_q.pdo[i], nmt_operational),
                        st_q.pdo[i].evt_cnt[7:0], st_q.pdo[i].sync_cnt};
        end
      end
    end

    // Time base: 100 us ticks, and a millisecond every tenth
    if (st_q.pre_cnt == 18'(INHIBIT_UNIT_CYCLES - 1)) begin
      st_d.pre_cnt = '0;
      tick100 = 1'b1;
      if (st_q.ms_cnt == 4'(tpdo_pkg::EVENT_PER_INHIBIT - 1)) begin
        st_d.ms_cnt = '0;
        tick_ms = 1'b1;
      end else begin
        st_d.ms_cnt = st_q.ms_cnt + 4'h1;
      end
    end else begin
      st_d.pre_cnt = st_q.pre_cnt + 18'h1;
    end

    // Payload scan: fetch each mapped object in turn, then decide
    case (st_q.scan)
      tpdo_pkg::SCAN_FETCH: begin
        if (st_q.entry < cur.map_cnt) begin
          nbytes = cur.map[st_q.entry[1:0]][6:3];
          st_d.build = put_bytes(st_q.build, st_q.offset, obj_value, nbytes);
          st_d.offset = st_q.offset + nbytes;
          st_d.entry = st_q.entry + 3'h1;
        end else begin
          st_d.scan = tpdo_pkg::SCAN_DECIDE;
        end
      end
      tpdo_pkg::SCAN_DECIDE: begin
        sdata = st_q.build;
        sdlc = st_q.offset;
        changed = !cur.sent_once || (st_q.build != cur.last);
        if (!pdo_active(cur, nmt_operational)) begin
          st_d.pdo[p].sync_hit = 1'b0;
          st_d.pdo[p].rtr_hit = 1'b0;
          st_d.pdo[p].tmr_hit = 1'b0;
        end else begin
          if (cur.tx_type == tpdo_pkg::TT_SYNC_ACYCLIC) begin
            if (cur.sync_hit) begin
              st_d.pdo[p].sync_hit = 1'b0;
              send = changed;
            end
          end else if (cur.tx_type <= tpdo_pkg::TT_SYNC_MAX) begin
            if (cur.sync_hit) begin
              st_d.pdo[p].sync_hit = 1'b0;
              next_cnt = cur.sync_cnt + 8'h1;
              if (next_cnt >= cur.tx_type) begin
                st_d.pdo[p].sync_cnt = '0;
                send = 1'b1;
              end else begin
                st_d.pdo[p].sync_cnt = next_cnt;
              end
            end
          end else if (cur.tx_type == tpdo_pkg::TT_SYNC_RTR) begin
            if (cur.sync_hit) begin
              st_d.pdo[p].sync_hit = 1'b0;
              st_d.pdo[p].latched = st_q.build;
              st_d.pdo[p].latched_dlc = st_q.offset;
            end
            if (cur.rtr_hit) begin
              st_d.pdo[p].rtr_hit = 1'b0;
              send = 1'b1;
              sdata = cur.latched;
              sdlc = cur.latched_dlc;
            end
          end else if (cur.tx_type == tpdo_pkg::TT_RTR_ONLY) begin
            if (cur.rtr_hit) begin
              st_d.pdo[p].rtr_hit = 1'b0;
              send = 1'b1;
            end
          end else if (cur.tx_type == tpdo_pkg::TT_TIMER) begin
            if (cur.tmr_hit) begin
              st_d.pdo[p].tmr_hit = 1'b0;
              send = 1'b1;
            end
          end else if (cur.tx_type == tpdo_pkg::TT_CHANGE) begin
            st_d.pdo[p].tmr_hit = 1'b0;
            send = cur.tmr_hit || (changed && !cur.due);
          end else begin
            // Reserved types never transmit
            st_d.pdo[p].sync_hit = 1'b0;
            st_d.pdo[p].rtr_hit = 1'b0;
            st_d.pdo[p].tmr_hit = 1'b0;
          end
        end
        if (send) begin
          st_d.pdo[p].due = 1'b1;
          st_d.pdo[p].due_data = sdata;
          st_d.pdo[p].due_dlc = sdlc;
        end
        st_d.scan = tpdo_pkg::SCAN_FETCH;
        st_d.pidx = !st_q.pidx;
        st_d.entry = '0;
        st_d.offset = '0;
        st_d.build = '0;
      end
      default: st_d.scan = tpdo_pkg::SCAN_FETCH;
    endcase

    // Transmit side: frame held until the controller takes it
    if (st_q.tx_busy && tx_ready) begin
      st_d.tx_busy = 1'b0;
    end

    sync_evt = rx_frame.valid && !rx_frame.rtr &&
               (rx_frame.id == st_q.sync_id[10:0]) && nmt_operational;

    for (int i = 0; i < tpdo_pkg::NUM_TPDO; i++) begin
      // Inhibit countdown on the 100 us tick
      if (tick100 && st_q.pdo[i].inh_cnt != 17'h0) begin
        st_d.pdo[i].inh_cnt = st_q.pdo[i].inh_cnt - 17'h1;
      end
      // Event timer runs for the asynchronous types only
      if (tick_ms && st_q.pdo[i].event_timer != 16'h0 &&
          st_q.pdo[i].tx_type >= tpdo_pkg::TT_TIMER &&
          pdo_active(st_q.pdo[i], nmt_operational)) begin
        if (st_q.pdo[i].evt_cnt + 16'h1 >= st_q.pdo[i].event_timer) begin
          st_d.pdo[i].evt_cnt = '0;
          st_d.pdo[i].tmr_hit = 1'b1;
        end else begin
          st_d.pdo[i].evt_cnt = st_q.pdo[i].evt_cnt + 16'h1;
        end
      end
      // Leaving operational drops anything still pending
      if (!pdo_active(st_q.pdo[i], nmt_operational)) begin
        st_d.pdo[i].due = 1'b0;
      end else if (st_q.pdo[i].due && st_q.pdo[i].inh_cnt == 17'h0 &&
                   !st_d.tx_busy) begin
        // Lower PDO wins when both are ready in one cycle
        st_d.tx_busy = 1'b1;
        st_d.tx.id = st_q.pdo[i].frame_id[10:0];
        st_d.tx.dlc = st_q.pdo[i].due_dlc;
        st_d.tx.data = st_q.pdo[i].due_data;
        st_d.pdo[i].due = 1'b0;
        st_d.pdo[i].last = st_q.pdo[i].due_data;
        st_d.pdo[i].sent_once = 1'b1;
        st_d.pdo[i].evt_cnt = '0;
        // One extra unit because the first tick may arrive at once
        st_d.pdo[i].inh_cnt = (st_q.pdo[i].inhibit == 16'h0) ? 17'h0 :
                              {1'b0, st_q.pdo[i].inhibit} + 17'h1;
      end
      // Incoming events are set last so a set beats a same-cycle clear
      if (sync_evt) begin
        st_d.pdo[i].sync_hit = 1'b1;
      end
      if (rx_frame.valid && rx_frame.rtr && nmt_operational &&
          !st_q.pdo[i].frame_id[tpdo_pkg::ID_DISABLE_BIT] &&
          rx_frame.id == st_q.pdo[i].frame_id[10:0]) begin
        st_d.pdo[i].rtr_hit = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sync_id <= tpdo_pkg::SYNC_ID_RESET;
      st_q.pdo[0].tx_type <= tpdo_pkg::TX_TYPE_RESET;
      st_q.pdo[1].tx_type <= tpdo_pkg::TX_TYPE_RESET;
      st_q.scan <= tpdo_pkg::SCAN_FETCH;
    end else begin
      st_q <= st_d;
    end
  end

endmodule // tpdo_scheduler

// ==== tb/tpdo_checker.sv ====
// Assertions on the scheduler's ports
`timescale 1ns/1ps

module tpdo_checker #(
  parameter int unsigned INHIBIT_UNIT_CYCLES = tpdo_pkg::INHIBIT_UNIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [23:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [6:0] node_id,
  input wire logic nmt_operational,
  input wire tpdo_pkg::rx_frame_t rx_frame,
  input wire tpdo_pkg::tx_frame_t tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  input wire logic [31:0] obj_value
);
  logic rd_ok, comm, map;
  logic [7:0] sub;

  // ----------------------------------------------------------------
  // Decode of completed reads
  // ----------------------------------------------------------------
  assign rd_ok = avs_read && !avs_waitrequest;
  assign comm = avs_address[23:9] == 15'h0C00;
  assign map = avs_address[23:9] == 15'h0D00;
  assign sub = avs_address[7:0];

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_OFFLINE_QUIET: assert property (!nmt_operational && !$past(nmt_operational)
    |-> !$rose(tx_valid)) else $error("tx offline");
  AST_DLC_LIMIT: assert property (tx_valid
    |-> tx_frame.dlc <= 4'h8 && tx_frame.dlc != 4'h0) else $error("bad dlc");
  AST_COUNT_FIXED: assert property (rd_ok && comm && sub == 8'h00
    |-> avs_readdata == 32'h5) else $error("count not 5");
  AST_TYPE_WIDTH: assert property (rd_ok && comm && sub == 8'h02
    |-> avs_readdata[31:8] == 24'h0) else $error("type width");
  AST_ID_FIELDS: assert property (rd_ok && comm && sub == 8'h01
    |-> avs_readdata[30:11] == 20'h0) else $error("id spare bits");
  AST_INHIBIT_WIDTH: assert property (rd_ok && comm && sub == 8'h03
    |-> avs_readdata[31:16] == 16'h0) else $error("inhibit width");
  AST_TIMER_WIDTH: assert property (rd_ok && comm && sub == 8'h05
    |-> avs_readdata[31:16] == 16'h0) else $error("timer width");
  AST_MAP_COUNT: assert property (rd_ok && map && sub == 8'h00
    |-> avs_readdata <= 32'h4) else $error("map count");
  AST_ONE_WAIT: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##[1:2] !avs_waitrequest) else $error("bus answer late");
  AST_FRAME_HOLD: assert property (tx_valid && !tx_ready
    |=> tx_valid && $stable(tx_frame)) else $error("frame moved");
endmodule // tpdo_checker

bind tpdo_scheduler tpdo_checker #(.INHIBIT_UNIT_CYCLES(INHIBIT_UNIT_CYCLES)) checker_u (
  .clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
  .avs_waitrequest, .node_id, .nmt_operational, .rx_frame, .tx_frame, .tx_valid, .tx_ready,
  .obj_index, .obj_sub, .obj_value);

// ==== tb/can_network_model.sv ====
// Network partner: SYNC producer, remote requester and frame sink
`timescale 1ns/1ps

module can_network_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] stall,
  input wire logic tx_valid,
  output tpdo_pkg::rx_frame_t rx_frame,
  output logic tx_ready
);
  logic [1:0] hold_q;

  // ----------------------------------------------------------------
  // Frame sink with a hold-off, as a busy bus would impose
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= 2'h0;
    end else if (!tx_valid || tx_ready) begin
      hold_q <= stall;
    end else begin
      hold_q <= hold_q - 2'h1;
    end
  end
  assign tx_ready = tx_valid && hold_q == 2'h0;

  // Idle bus carries no frame
  initial rx_frame = '0;

  // One frame for one cycle; a SYNC has no payload, only its identifier
  // Idle id is inverted so nothing can lean on a stale value
  task automatic send(input logic rtr, input logic [10:0] id);
    rx_frame <= '{valid: 1'b1, rtr: rtr, id: id};
    @(posedge clock);
    rx_frame <= '{valid: 1'b0, rtr: !rtr, id: ~id};
    @(posedge clock);
  endtask
endmodule // can_network_model

// ==== tb/tb_transmit_pdo_sync_scheduler.sv ====
// Self-checking bench for the scheduler
`timescale 1ns/1ps

module tb_transmit_pdo_sync_scheduler;
  localparam int unsigned UNIT = 4;
  localparam int EVT = 2 * tpdo_pkg::EVENT_PER_INHIBIT * UNIT;
  localparam logic [15:0] COMM = tpdo_pkg::IDX_COMM_BASE;
  localparam logic [15:0] MAPI = tpdo_pkg::IDX_MAP_BASE;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, seen;
  logic nmt_operational, tx_valid, tx_ready;
  logic [23:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, obj_value, rdata;
  logic [6:0] node_id;
  tpdo_pkg::rx_frame_t rx_frame;
  tpdo_pkg::tx_frame_t tx_frame, f, e;
  logic [15:0] obj_index;
  logic [7:0] obj_sub;
  logic [31:0] vals [4];
  logic [31:0] nv [2];
  logic [1:0] stall;
  logic [10:0] id0;
  int n_fail, comparisons, t;

  // Object store answers in the same cycle
  assign obj_value = vals[obj_index[1:0]];

  tpdo_scheduler #(.INHIBIT_UNIT_CYCLES(UNIT)) dut_u (
    .clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .node_id, .nmt_operational, .rx_frame, .tx_frame, .tx_valid, .tx_ready,
    .obj_index, .obj_sub, .obj_value);

  can_network_model can_u (.clock, .rst_n, .stall, .tx_valid, .rx_frame, .tx_ready);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Checking, bus and frame tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [79:0] sv, input logic [79:0] xv);
    comparisons++;
    if (sv !== xv) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, xv, sv);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [23:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      check("bus answer", 80'(1), 80'(0));
      final_report();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    acc(1'b1, {i, s}, d);
  endtask

  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
    acc(1'b0, {i, s}, 32'h0);
    check($sformatf("reg %h_%h", i, s), 80'(rdata), 80'(x));
  endtask

  // Last-fetched object only, so a scan never sees a half-new payload
  task automatic shuffle();
    nv[1] = $urandom();
    vals[1] <= nv[1];
  endtask

  // Payload: 16-bit then 32-bit object, little-endian
  function automatic tpdo_pkg::tx_frame_t exp_frame(input logic [10:0] id);
    exp_frame = '0;
    exp_frame.id = id;
    exp_frame.dlc = 4'h6;
    exp_frame.data[15:0] = nv[0][15:0];
    exp_frame.data[47:16] = nv[1];
  endfunction

  // Watch for an accepted frame; the sink stalls a random 0..3 cycles
  task automatic wait_tx(input int lim);
    stall <= 2'($urandom_range(0, 3));
    seen = 1'b0;
    t = 0;
    while (!seen && t < lim) begin
      @(posedge clock);
      t++;
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        seen = 1'b1;
        f = tx_frame;
      end
    end
  endtask

  task automatic expect_tx(input logic want, input tpdo_pkg::tx_frame_t x, input int lim);
    wait_tx(lim);
    check("frame sent", 80'(seen), 80'(want));
    if (want && seen) begin
      check("frame", 80'(f), 80'(x));
    end
    if (want && !seen) begin
      final_report();
    end
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    check("run time", 80'(1), 80'(0));
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    t = $urandom(44);
    comparisons = 0;
    n_fail = 0;
    rst_n = 1'b0;
    avs_address = 24'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    nmt_operational = 1'b0;
    stall = 2'h0;
    e = '0;
    node_id = 7'($urandom_range(1, 127));
    nv[0] = $urandom();
    vals[0] = nv[0];
    shuffle();
    id0 = tpdo_pkg::FRAME_ID_BASE0 + 11'(node_id);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(tpdo_pkg::IDX_SYNC_ID, 8'h00, 32'h80);
    rd(COMM, 8'h01, 32'(id0));
    rd(COMM + 16'h1, 8'h01, 32'(tpdo_pkg::FRAME_ID_BASE1 + 11'(node_id)));
    rd(COMM, 8'h02, 32'hFE);
    rd(COMM, 8'h03, 32'h0);
    rd(COMM, 8'h05, 32'h0);
    rd(MAPI, 8'h00, 32'h0);
    rd(MAPI, 8'h04, 32'h0);
    rd(COMM, 8'h04, 32'h0);
    rd(16'h3000, 8'h00, 32'h0);
    wr(COMM, 8'h00, 32'h7);
    rd(COMM, 8'h00, 32'h5);
    // 128 bits overflow the payload; five objects are too many
    for (int k = 1; k <= 4; k++) begin
      wr(MAPI, 8'(k), 32'h2000_0020);
    end
    wr(MAPI, 8'h00, 32'h4);
    rd(MAPI, 8'h00, 32'h0);
    wr(MAPI, 8'h00, 32'h5);
    rd(MAPI, 8'h00, 32'h0);
    wr(MAPI, 8'h01, 32'h2000_0010);
    wr(MAPI, 8'h02, 32'h2001_0020);
    wr(MAPI, 8'h00, 32'h2);
    rd(MAPI, 8'h00, 32'h2);
    wr(MAPI, 8'h02, 32'h0);
    rd(MAPI, 8'h02, 32'h2001_0020);
    wr(COMM, 8'h02, 32'h1);
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b0, e, 40);
    nmt_operational <= 1'b1;
    for (int n = 1; n <= 3; n++) begin
      wr(COMM, 8'h02, 32'(n));
      for (int s = 1; s <= 2 * n; s++) begin
        shuffle();
        can_u.send(1'b0, 11'h080);
        expect_tx(s % n == 0, exp_frame(id0), 40);
      end
    end
    wr(COMM, 8'h02, 32'h1);
    wr(tpdo_pkg::IDX_SYNC_ID, 8'h00, 32'h81);
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b0, e, 40);
    can_u.send(1'b0, 11'h081);
    expect_tx(1'b1, exp_frame(id0), 40);
    wr(tpdo_pkg::IDX_SYNC_ID, 8'h00, 32'h80);
    wr(COMM, 8'h02, 32'h0);
    shuffle();
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b1, exp_frame(id0), 40);
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b0, e, 40);
    wr(COMM, 8'h02, 32'hFC);
    shuffle();
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b0, e, 30);
    e = exp_frame(id0);
    shuffle();
    can_u.send(1'b1, id0);
    expect_tx(1'b1, e, 40);
    wr(COMM, 8'h03, 32'h5);
    wr(COMM, 8'h02, 32'hFF);
    expect_tx(1'b1, exp_frame(id0), 60);
    // A change just after a send waits out the inhibit
    shuffle();
    wait_tx(100);
    check("inhibit gap", 80'(seen && t >= 5 * UNIT - 3), 80'(1));
    check("frame", 80'(f), 80'(exp_frame(id0)));
    expect_tx(1'b0, e, 40);
    wr(COMM, 8'h05, 32'h2); // 2 ms, twice the shortest non-zero period
    wr(COMM, 8'h02, 32'hFE);
    wait_tx(200);
    wait_tx(200);
    check("timer period", 80'(seen && t >= EVT - 8 && t <= EVT + 40), 80'(1));
    check("frame", 80'(f), 80'(exp_frame(id0)));
    wr(COMM, 8'h02, 32'hFF);
    wait_tx(200);
    check("timer on change type", 80'(seen && t <= EVT + 40), 80'(1));
    wr(COMM, 8'h05, 32'h0);
    wr(COMM, 8'h02, 32'hFD);
    id0 = 11'($urandom_range(256, 2047));
    wr(COMM, 8'h01, 32'h7FFF_F800 | 32'(id0));
    rd(COMM, 8'h01, 32'(id0));
    shuffle();
    can_u.send(1'b1, id0);
    expect_tx(1'b1, exp_frame(id0), 40);
    can_u.send(1'b0, 11'h080);
    expect_tx(1'b0, e, 40);
    wr(COMM, 8'h01, 32'h8000_0000 | 32'(id0));
    can_u.send(1'b1, id0);
    expect_tx(1'b0, e, 40);
    wr(COMM, 8'h01, 32'(id0));
    wr(MAPI, 8'h00, 32'h0);
    can_u.send(1'b1, id0);
    expect_tx(1'b0, e, 40);
    final_report();
  end
endmodule // tb_transmit_pdo_sync_scheduler
